// ### testbench/mbda_bank_decode_tb.sv
// bench: register bus and access port tests for the bank decode block
module mbda_bank_decode_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import mbda_pkg::*;
    logic clk_in = 1'b0, rst_in = 1'b1, boot_select_en_in = 1'b1, req_valid_in = 1'b0;
    logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
    logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
    logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0000_0000;
    logic [3:0] s_axi_wstrb_in = 4'hf;
    logic [1:0] pm_mode = 2'h0;
    mbda_req_type req_in = '0;
    logic [1:0] size_ack_in, s_axi_bresp_out, s_axi_rresp_out, size_ack_out, burst_addr_out;
    logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic s_axi_rvalid_out, transfer_ack_in, row_col_select_out, size_ack_oe_out;
    logic transfer_ack_out, transfer_ack_oe_out, parity_check_out, req_done_out, req_fault_out;
    logic [31:0] s_axi_rdata_out, got, mem_addr_out, col_a;
    logic [3:0] bank_sel_n_out, sel_min;
    logic [1:0] ack_sz, resp;
    logic [7:0] bseq;
    logic flt, par_seen, rc_low, sel_ack;
    int error_cnt = 0;
    int compares = 0;
    int n, ta_cnt;

    mbda_bank_decode DUT (
        .clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in,
        .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
        .s_axi_rvalid_out, .s_axi_rready_in, .boot_select_en_in, .req_in, .req_valid_in,
        .size_ack_in, .transfer_ack_in, .bank_sel_n_out, .row_col_select_out,
        .mem_addr_out, .size_ack_out, .size_ack_oe_out, .transfer_ack_out,
        .transfer_ack_oe_out, .burst_addr_out, .parity_check_out, .req_done_out,
        .req_fault_out);
    mbda_mem_model #(.ACK_DLY(3)) partner (
        .clk_in, .bank_sel_n_in(bank_sel_n_out), .mode_in(pm_mode),
        .size_ack_out(size_ack_in), .transfer_ack_out(transfer_ack_in));

    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one transfer on the register bus; valids drop on their own ready
    task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        s_axi_awaddr_in <= a;
        s_axi_araddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= w;
        s_axi_wvalid_in <= w;
        s_axi_bready_in <= w;
        s_axi_arvalid_in <= !w;
        s_axi_rready_in <= !w;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
            if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
            if (w ? s_axi_bvalid_out : s_axi_rvalid_out) break;
        end
        if (i == 50) begin
            error_cnt++;
            close_out();
        end
        got = s_axi_rdata_out;
        resp = w ? s_axi_bresp_out : s_axi_rresp_out;
        s_axi_bready_in <= 1'b0;
        s_axi_rready_in <= 1'b0;
    endtask

    // one access; request held until the done pulse is seen
    task automatic acc(input logic w, input logic [1:0] m, input logic [3:0] sp,
                       input logic [31:0] a = 32'h1000_0000, input logic b = 1'b0);
        @(posedge clk_in);
        req_in <= '{a, sp, w, m, b};
        req_valid_in <= 1'b1;
        sel_min = 4'hf;
        ack_sz = 2'h0;
        ta_cnt = 0;
        bseq = 8'h00;
        {par_seen, rc_low, sel_ack} = 3'h0;
        col_a = 32'h0;
        for (n = 1; n < 200; n++) begin
            @(posedge clk_in);
            #1;
            sel_min &= bank_sel_n_out;
            par_seen |= parity_check_out;
            rc_low |= !row_col_select_out;
            if (!row_col_select_out) col_a = mem_addr_out;
            if (size_ack_oe_out) ack_sz |= size_ack_out;
            if (size_ack_oe_out || transfer_ack_oe_out) sel_ack = bank_sel_n_out[1];
            if (transfer_ack_oe_out && transfer_ack_out) begin
                ta_cnt++;
                bseq = {bseq[5:0], burst_addr_out};
            end
            if (req_done_out) break;
        end
        if (n == 200) begin
            error_cnt++;
            close_out();
        end
        flt = req_fault_out;
        req_valid_in <= 1'b0;
    endtask

    // bank 1 sits at 0x1000_0000; base flags are relax,back,alt,early,parity,lock,valid
    function automatic logic [31:0] bb(input logic [6:0] f, input logic [3:0] sp);
        return {21'h2_0000, sp, f};
    endfunction
    function automatic logic [31:0] ob(input logic [3:0] t, input logic [3:0] fm,
                                       input logic [1:0] sps, input logic d);
        return {t, 17'h1_ffff, fm, 4'h0, sps, d};
    endfunction

    initial begin
        repeat (16) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        axi(1'b0, 8'h00, 32'h0);
        chk("base0", got, 32'h0000_0051);
        axi(1'b0, 8'h0c, 32'h0);
        chk("option1", got, 32'hf000_0000);
        axi(1'b0, 8'h08, 32'h0);
        chk("base1", got, 32'h0000_0050);
        axi(1'b0, 8'h20, 32'h0);
        chk("unmapped", {got[29:0], resp}, 32'h2);
        axi(1'b1, 8'h48, 32'h0);
        chk("unmapped write", 32'(resp), 32'h2);
        $display("test registers done");
        axi(1'b1, 8'h08, bb(7'h00, 4'h5));
        chk("write ok", 32'(resp), 32'h0);
        axi(1'b1, 8'h0c, ob(4'h1, 4'hf, 2'h0, 1'b0));
        acc(1'b0, 2'h0, 4'h5);
        chk("invalid bank", 32'({flt, sel_min}), 32'h1f);
        axi(1'b1, 8'h08, bb(7'h01, 4'h5));
        acc(1'b0, 2'h0, 4'h5);
        chk("hit", 32'({flt, sel_min, ack_sz, 4'(n)}), 32'h375);
        acc(1'b0, 2'h0, 4'h6);
        chk("space miss", 32'(flt), 32'h1);
        acc(1'b0, 2'h0, 4'h5, 32'h1010_0000);
        chk("mask miss", 32'(flt), 32'h1);
        axi(1'b1, 8'h0c, 32'h1fef_f800);
        acc(1'b0, 2'h0, 4'h6, 32'h1010_0000);
        chk("masked hit", 32'(flt), 32'h0);
        $display("test decode done");
        axi(1'b1, 8'h08, bb(7'h03, 4'h0));
        axi(1'b1, 8'h0c, ob(4'h1, 4'h0, 2'h0, 1'b0));
        acc(1'b1, 2'h0, 4'h0);
        chk("locked write", 32'({flt, sel_min, ack_sz}), 32'h7c);
        axi(1'b0, 8'h44, 32'h0);
        chk("violation flag", got, 32'h1);
        acc(1'b0, 2'h0, 4'h0);
        chk("locked read", 32'(flt), 32'h0);
        axi(1'b1, 8'h44, 32'h1);
        axi(1'b0, 8'h44, 32'h0);
        chk("flag cleared", got, 32'h0);
        axi(1'b1, 8'h08, bb(7'h01, 4'h0));
        axi(1'b1, 8'h10, bb(7'h01, 4'h0));
        axi(1'b1, 8'h14, ob(4'h1, 4'h0, 2'h0, 1'b0));
        acc(1'b0, 2'h0, 4'h0);
        chk("two hits", 32'(sel_min), 32'hd);
        axi(1'b1, 8'h10, 32'h0);
        $display("test lock and priority done");
        for (int k = 0; k < 3; k++) begin
            axi(1'b1, 8'h0c, ob(4'h0, 4'h0, 2'(k), 1'b0));
            acc(1'b0, 2'h0, 4'h0);
            chk("size ack", 32'({ack_sz, 4'(n)}), 32'({2'(3 - k), 4'h4}));
        end
        axi(1'b1, 8'h0c, ob(4'h0, 4'h0, 2'h3, 1'b0));
        pm_mode <= 2'h1;
        acc(1'b0, 2'h0, 4'h0);
        chk("external size end", 32'({flt, ack_sz}), 32'h0);
        pm_mode <= 2'h2;
        acc(1'b0, 2'h2, 4'h0);
        chk("external transfer end", 32'({flt, ta_cnt[3:0]}), 32'h0);
        pm_mode <= 2'h0;
        axi(1'b1, 8'h0c, ob(4'h0, 4'h0, 2'h0, 1'b0));
        acc(1'b0, 2'h2, 4'h0);
        chk("burst master ack", 32'({ack_sz, ta_cnt[3:0]}), 32'h1);
        $display("test port width done");
        axi(1'b1, 8'h08, bb(7'h41, 4'h0));
        acc(1'b0, 2'h0, 4'h0);
        chk("relaxed length", 32'(n), 32'h5);
        axi(1'b1, 8'h40, 32'h2);
        axi(1'b1, 8'h0c, ob(4'h0, 4'h0, 2'h0, 1'b1));
        acc(1'b0, 2'h0, 4'h0);
        chk("dram relaxed", 32'(n), 32'h6);
        axi(1'b1, 8'h08, bb(7'h01, 4'h0));
        acc(1'b0, 2'h0, 4'h0);
        chk("dram length", 32'({rc_low, 4'(n)}), 32'h15);
        chk("column address", col_a, 32'h0002_0000);
        // early release only on SRAM writes, never for external masters outside lockstep mode
        axi(1'b1, 8'h0c, ob(4'h1, 4'h0, 2'h0, 1'b0));
        axi(1'b1, 8'h08, bb(7'h09, 4'h0));
        acc(1'b1, 2'h0, 4'h0);
        chk("early release", 32'({sel_ack, 4'(n)}), 32'h15);
        acc(1'b1, 2'h1, 4'h0);
        chk("early ignored", 32'(sel_ack), 32'h0);
        axi(1'b1, 8'h40, 32'h3);
        axi(1'b1, 8'h08, bb(7'h11, 4'h0));
        acc(1'b1, 2'h2, 4'h0);
        chk("early alt", 32'(sel_ack), 32'h1);
        axi(1'b1, 8'h08, bb(7'h05, 4'h0));
        acc(1'b0, 2'h1, 4'h0);
        chk("sync parity", 32'(par_seen), 32'h1);
        axi(1'b1, 8'h40, 32'h2);
        acc(1'b0, 2'h1, 4'h0);
        chk("async parity", 32'(par_seen), 32'h0);
        axi(1'b1, 8'h08, bb(7'h01, 4'h0));
        acc(1'b0, 2'h0, 4'h0);
        chk("parity off", 32'(par_seen), 32'h0);
        $display("test timing and parity done");
        axi(1'b1, 8'h08, bb(7'h21, 4'h0));
        acc(1'b0, 2'h2, 4'h0, 32'h1000_0004, 1'b1);
        chk("burst beats", 32'({ta_cnt[3:0], bseq}), 32'h46c);
        $display("test burst done");
        // top pins carry strobes: bits 31:28 leave the compare, so bank 0 matches and wins
        axi(1'b1, 8'h40, 32'h4);
        acc(1'b0, 2'h1, 4'h0);
        chk("top pins strobes", 32'({sel_min, 8'(n)}), 32'he13);
        pm_mode <= 2'h1;
        acc(1'b0, 2'h1, 4'h0);
        chk("agent early end", 32'({ack_sz, 4'(n)}), 32'h8);
        $display("test strobes and early end done");
        close_out();
    end
endmodule

// ### testbench/mbda_mem_model.sv
// far-side bank model: answers on the acknowledge lines inside the select window
module mbda_mem_model #(
    parameter int ACK_DLY = 3
) (
    input wire logic clk_in,
    input wire logic [3:0] bank_sel_n_in,
    input wire logic [1:0] mode_in,
    output logic [1:0] size_ack_out,
    output logic transfer_ack_out
);
    int cnt_q;
    always_ff @(posedge clk_in) begin
        if (&bank_sel_n_in) begin
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
    // never answers before a select is low, and lets go as soon as it rises
    // released lines read inactive: the real pins idle high through pull-ups
    // the count clears one edge late, so gate on the select itself to avoid a stray ack
    wire sel_low = !(&bank_sel_n_in);
    assign size_ack_out = (sel_low && mode_in == 2'h1 && cnt_q >= ACK_DLY) ? 2'h3 : 2'h0;
    assign transfer_ack_out = sel_low && mode_in == 2'h2 && cnt_q >= ACK_DLY;
endmodule

// ### verilog/mbda_bank_decode.sv
// bank base/option decode, attribute timing and register slave
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`include "mbda_cfg.svh"
// Behaviour
// - a bank's select never asserts unless its valid bit is one
// - writes to a locked bank: no select, no acks, violation flag set
// - parity check only with parity enable, never for asynchronous external masters
// - early release drops select two steps early on SRAM writes, same length
// - alternate early release does the same for burst-master writes
// - timing tweaks ignored for SRAM external cycles without lockstep mode
// - burst enable acknowledges bursts and drives incrementing address bits 3:2
// - relaxed start delays select one step and adds one clock
// - DRAM relaxed start delays row strobe, then column select further
// - bus space code is compared with the bank space code
// - internal masters compare address bits 31:11 and space code
// - external masters compare bits 31:28 unless those pins carry strobes
// - bank type selects SRAM or DRAM length, muxing and row release
// - port width: 32, 16, 8 bits, or external size acknowledge
// - internal end drives size acks; external end only samples them
// - burst master gets transfer ack instead; external mode samples it
// - size acks still sampled so an agent may end the cycle early
// - after reset bank zero is valid if the boot select pin says so
// - cleared mask bits drop address bits from the comparison
// - cleared space mask bits drop space code bits from the comparison
// - with two hits only the lower-numbered bank selects
// - length field sets wait states; DRAM length is field plus three
module mbda_bank_decode
    import mbda_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic boot_select_en_in,
    input wire mbda_req_type req_in,
    input wire logic req_valid_in,
    input wire logic [1:0] size_ack_in,
    input wire logic transfer_ack_in,
    output logic [3:0] bank_sel_n_out,
    output logic row_col_select_out,
    output logic [31:0] mem_addr_out,
    output logic [1:0] size_ack_out,
    output logic size_ack_oe_out,
    output logic transfer_ack_out,
    output logic transfer_ack_oe_out,
    output logic [1:0] burst_addr_out,
    output logic parity_check_out,
    output logic req_done_out,
    output logic req_fault_out
);
    function automatic logic bank_hit(input mbda_req_type r, input logic [31:0] b,
                                      input logic [31:0] o, input logic top_cmp);
        logic [20:0] m;
        m = {{4{top_cmp}}, o[27:11]};
        return b[`MBDA_BR_VALID] && (((r.addr[31:11] ^ b[31:11]) & m) == 21'h0_0000)
            && (((r.space ^ b[10:7]) & o[10:7]) == 4'h0);
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    logic [31:0] br_q [`MBDA_NBANK];
    logic [31:0] or_q [`MBDA_NBANK];
    logic [31:0] ctrl_q;
    logic wvf_q;
    logic init_q;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    mbda_state_type st_q;
    mbda_attr_type att_q;
    logic [4:0] up_q;
    logic [1:0] beat_q;
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    // pins from outside the clock domain pass two flops first
    always_ff @(posedge clk_in) begin
        sync1_q <= {boot_select_en_in, transfer_ack_in, size_ack_in};
        sync2_q <= sync1_q;
    end
    wire [1:0] size_ack_s = sync2_q[1:0];
    wire tack_s = sync2_q[2];
    wire boot_s = sync2_q[3];

    // address and space decode
    wire ext_m = req_in.master != `MBDA_M_INT;
    wire bm_m = req_in.master == `MBDA_M_BURST;
    wire top_cmp = !ext_m || !ctrl_q[`MBDA_CTRL_TOPSTRB];
    wire [3:0] hit;
    for (genvar g = 0; g < `MBDA_NBANK; g++) begin : g_hit
        assign hit[g] = bank_hit(req_in, br_q[g], or_q[g], top_cmp);
    end
    wire found = |hit;
    wire [1:0] idx = hit[0] ? 2'd0 : hit[1] ? 2'd1 : hit[2] ? 2'd2 : 2'd3;
    wire [31:0] b_s = br_q[idx];
    wire [31:0] o_s = or_q[idx];

    // attributes of the hit bank for this request
    wire dram_s = o_s[0];
    wire async_s = ext_m && !ctrl_q[`MBDA_CTRL_LOCKSTEP];
    wire tim_ok = dram_s || !async_s;
    wire early_pick = bm_m ? b_s[`MBDA_BR_EARLY_ALT] : b_s[`MBDA_BR_EARLY];
    wire early_s = !dram_s && req_in.write && tim_ok && early_pick;
    wire relax_s = b_s[`MBDA_BR_RELAX] && !bm_m && tim_ok;
    wire locked_s = req_in.write && b_s[`MBDA_BR_WLOCK];
    wire burst_s = bm_m && req_in.burst && b_s[`MBDA_BR_BACK] && !dram_s;
    wire [4:0] extra = dram_s ? `MBDA_DRAM_EXTRA : `MBDA_SRAM_EXTRA;
    wire [4:0] len_s = {1'b0, o_s[31:28]} + extra;
    wire launch = st_q == ST_IDLE && req_valid_in && found && !locked_s;
    wire [3:0] sel_s = ~(4'h1 << idx);
    wire [3:0] sel_a = ~(4'h1 << att_q.bank);
    wire sps_ext_a = !att_q.dram && att_q.sps == `MBDA_SPS_EXT;
    wire last_run = up_q == att_q.len - 5'h01;
    wire col_step = up_q == {4'h0, att_q.relax};
    wire mux_on = att_q.dram && ctrl_q[`MBDA_CTRL_ROWCOL];
    wire [1:0] ack_code = att_q.sps == 2'h0 ? `MBDA_ACK_W32 :
                          att_q.sps == 2'h1 ? `MBDA_ACK_W16 : `MBDA_ACK_W8;
    // early end by an outside agent; the burst master ends on transfer ack only
    wire ext_end = sps_ext_a ? (att_q.bm ? tack_s : |size_ack_s)
                             : (!att_q.bm && |size_ack_s);

    // access sequencer; one step of select timing is one clock here
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= ST_IDLE;
            att_q <= '0;
            up_q <= 5'h00;
            beat_q <= 2'h0;
            bank_sel_n_out <= 4'hF;
            row_col_select_out <= 1'b1;
            mem_addr_out <= 32'h0000_0000;
            size_ack_out <= 2'h0;
            size_ack_oe_out <= 1'b0;
            transfer_ack_out <= 1'b0;
            transfer_ack_oe_out <= 1'b0;
            burst_addr_out <= 2'h0;
            parity_check_out <= 1'b0;
            req_done_out <= 1'b0;
            req_fault_out <= 1'b0;
        end else begin
            req_done_out <= 1'b0;
            req_fault_out <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (req_valid_in && (!found || locked_s)) begin
                        req_done_out <= 1'b1;
                        req_fault_out <= 1'b1;
                    end else if (launch) begin
                        att_q <= '{bank: idx, dram: dram_s, early: early_s, relax: relax_s,
                                   burst: burst_s, bm: bm_m, async_m: async_s,
                                   sps: o_s[2:1], bcyc: o_s[6:5], len: len_s,
                                   addr: req_in.addr};
                        up_q <= 5'h00;
                        beat_q <= req_in.addr[3:2];
                        burst_addr_out <= req_in.addr[3:2];
                        mem_addr_out <= req_in.addr;
                        row_col_select_out <= 1'b1;
                        parity_check_out <= b_s[`MBDA_BR_PARITY_CHECK_ON] && !async_s;
                        st_q <= relax_s ? ST_LEAD : ST_RUN;
                        bank_sel_n_out <= relax_s ? 4'hF : sel_s;
                    end
                end
                ST_LEAD: begin
                    bank_sel_n_out <= sel_a;
                    st_q <= ST_RUN;
                end
                ST_RUN: begin
                    up_q <= up_q + 5'h01;
                    if (col_step) begin
                        row_col_select_out <= 1'b0;
                        if (mux_on) begin
                            mem_addr_out <= {11'h000, att_q.addr[31:11]};
                        end
                    end
                    if (att_q.early && up_q == att_q.len - 5'h02) begin
                        bank_sel_n_out <= 4'hF;
                    end
                    if (ext_end) begin
                        st_q <= ST_ENDS;
                    end else if (last_run && !sps_ext_a) begin
                        size_ack_out <= ack_code;
                        size_ack_oe_out <= !att_q.bm;
                        transfer_ack_out <= att_q.bm;
                        transfer_ack_oe_out <= att_q.bm;
                        st_q <= ST_ENDS;
                    end
                end
                ST_ENDS: begin
                    size_ack_out <= 2'h0;
                    size_ack_oe_out <= 1'b0;
                    transfer_ack_out <= 1'b0;
                    transfer_ack_oe_out <= 1'b0;
                    if (att_q.burst && beat_q != att_q.addr[3:2] - 2'h1) begin
                        beat_q <= beat_q + 2'h1;
                        burst_addr_out <= beat_q + 2'h1;
                        att_q.len <= {3'h0, att_q.bcyc} + 5'h01;
                        att_q.early <= 1'b0;
                        up_q <= 5'h00;
                        bank_sel_n_out <= sel_a;
                        st_q <= ST_RUN;
                    end else begin
                        bank_sel_n_out <= 4'hF;
                        row_col_select_out <= 1'b1;
                        parity_check_out <= 1'b0;
                        req_done_out <= 1'b1;
                        st_q <= ST_IDLE;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // register slave
    wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
    wire w_take = s_axi_wvalid_in && s_axi_wready_out;
    wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_out;
    wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
    wire aw_next = (aw_have_q && !wr_fire) || aw_take;
    wire w_next = (w_have_q && !wr_fire) || w_take;
    wire r_next = (s_axi_rvalid_out && !s_axi_rready_in) || ar_take;
    wire wr_bank = aw_addr_q < `MBDA_BANK_SPAN;
    wire wr_ctrl = aw_addr_q == `MBDA_CTRL_OFS;
    wire wr_stat = aw_addr_q == `MBDA_STAT_OFS;
    wire wr_ok = wr_bank || wr_ctrl || wr_stat;
    wire [1:0] wbank = aw_addr_q[4:3];
    wire rd_bank = s_axi_araddr_in < `MBDA_BANK_SPAN;
    wire [1:0] rbank = s_axi_araddr_in[4:3];
    wire rd_ctrl = s_axi_araddr_in == `MBDA_CTRL_OFS;
    wire rd_stat = s_axi_araddr_in == `MBDA_STAT_OFS;
    wire rd_ok = rd_bank || rd_ctrl || rd_stat;
    wire [31:0] rd_word = rd_bank ? (s_axi_araddr_in[2] ? or_q[rbank] : br_q[rbank]) :
                          rd_ctrl ? ctrl_q : rd_stat ? {31'h0, wvf_q} : 32'h0000_0000;
    wire wvf_set = st_q == ST_IDLE && req_valid_in && found && locked_s;
    wire wvf_clr = wr_fire && wr_stat && w_strb_q[0] && w_data_q[0];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `MBDA_RESP_OK;
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rresp_out <= `MBDA_RESP_OK;
            s_axi_rdata_out <= 32'h0000_0000;
        end else begin
            aw_have_q <= aw_next;
            w_have_q <= w_next;
            s_axi_awready_out <= !aw_next;
            s_axi_wready_out <= !w_next;
            s_axi_arready_out <= !r_next;
            if (aw_take) begin
                aw_addr_q <= {s_axi_awaddr_in[7:2], 2'h0};
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata_in;
                w_strb_q <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_ok ? `MBDA_RESP_OK : `MBDA_RESP_ERR;
            end else if (s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
            if (ar_take) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out <= rd_word;
                s_axi_rresp_out <= rd_ok ? `MBDA_RESP_OK : `MBDA_RESP_ERR;
            end else if (s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // bank registers; bank zero is armed from the boot pin once after reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < `MBDA_NBANK; i++) begin
                br_q[i] <= `MBDA_BR_RST;
                or_q[i] <= `MBDA_OR_RST;
            end
            ctrl_q <= `MBDA_CTRL_RST;
            wvf_q <= 1'b0;
            init_q <= 1'b0;
        end else begin
            init_q <= 1'b1;
            wvf_q <= wvf_set || (wvf_q && !wvf_clr); // set wins over clear
            if (wr_fire && wr_bank && aw_addr_q[2]) begin
                or_q[wbank] <= merge_strb(or_q[wbank], w_data_q, w_strb_q);
            end
            if (wr_fire && wr_bank && !aw_addr_q[2]) begin
                br_q[wbank] <= merge_strb(br_q[wbank], w_data_q, w_strb_q);
            end
            if (!init_q) begin
                br_q[0][`MBDA_BR_VALID] <= boot_s;
            end
            if (wr_fire && wr_ctrl) begin
                ctrl_q <= merge_strb(ctrl_q, w_data_q, w_strb_q) & 32'h0000_0007;
            end
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_miss_no_select: assert property (
        st_q == ST_IDLE && req_valid_in && !found |=> bank_sel_n_out == 4'hF && req_fault_out)
        else $error("select or no fault on a miss");
    chk_lock_blocks: assert property (
        wvf_set |=> wvf_q && bank_sel_n_out == 4'hF && !size_ack_oe_out && !transfer_ack_oe_out)
        else $error("locked write was not blocked");
    chk_parity_sync: assert property (
        parity_check_out |-> !att_q.async_m)
        else $error("parity checked for asynchronous master");
    chk_relax_delay: assert property (
        launch && relax_s |=> bank_sel_n_out == 4'hF ##1 bank_sel_n_out != 4'hF)
        else $error("relaxed start did not delay select");
    chk_low_bank_wins: assert property (
        launch && !relax_s && hit[1] && hit[2] |=> !bank_sel_n_out[1] && bank_sel_n_out[2])
        else $error("higher bank selected");
    chk_ext_no_drive: assert property (
        size_ack_oe_out |-> !sps_ext_a && size_ack_out == ack_code)
        else $error("size ack driven wrongly");
    chk_boot_valid: assert property (
        !init_q |=> br_q[0][`MBDA_BR_VALID] == $past(boot_s))
        else $error("boot bank valid not taken");
    chk_dram_length: assert property (
        launch && dram_s && o_s[31:28] == 4'h0 && !relax_s && o_s[2:1] != `MBDA_SPS_EXT
        && !req_in.burst ##1 !ext_end [*3] |=> size_ack_oe_out || transfer_ack_oe_out)
        else $error("dram cycle length wrong");
endmodule

// ### verilog/mbda_cfg.svh
// offsets, field positions, reset values and codes of the bank decode block
`ifndef MBDA_CFG_SVH
`define MBDA_CFG_SVH
`define MBDA_NBANK 4
`define MBDA_BANK_SPAN 8'h20
`define MBDA_CTRL_OFS 8'h40
`define MBDA_STAT_OFS 8'h44
`define MBDA_BR_VALID 0
`define MBDA_BR_WLOCK 1
`define MBDA_BR_PARITY_CHECK_ON 2
`define MBDA_BR_EARLY 3
`define MBDA_BR_EARLY_ALT 4
`define MBDA_BR_BACK 5
`define MBDA_BR_RELAX 6
`define MBDA_BR_RST 32'h0000_0050
`define MBDA_OR_RST 32'hF000_0000
`define MBDA_CTRL_LOCKSTEP 0
`define MBDA_CTRL_ROWCOL 1
`define MBDA_CTRL_TOPSTRB 2
`define MBDA_CTRL_RST 32'h0000_0000
`define MBDA_SPS_EXT 2'h3
`define MBDA_ACK_W32 2'h3
`define MBDA_ACK_W16 2'h2
`define MBDA_ACK_W8 2'h1
`define MBDA_M_INT 2'h0
`define MBDA_M_BURST 2'h2
`define MBDA_RESP_OK 2'h0
`define MBDA_RESP_ERR 2'h2
`define MBDA_SRAM_EXTRA 5'h02
`define MBDA_DRAM_EXTRA 5'h03
`endif

// ### verilog/mbda_pkg.sv
// types shared by the bank decode block
package mbda_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LEAD = 4'b0010,
        ST_RUN = 4'b0100,
        ST_ENDS = 4'b1000
    } mbda_state_type;
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] space;
        logic write;
        logic [1:0] master;
        logic burst;
    } mbda_req_type;
    typedef struct packed {
        logic [1:0] bank;
        logic dram;
        logic early;
        logic relax;
        logic burst;
        logic bm;
        logic async_m;
        logic [1:0] sps;
        logic [1:0] bcyc;
        logic [4:0] len;
        logic [31:0] addr;
    } mbda_attr_type;
endpackage
